// ---- design/eip_consts.svh ----
// Constants of the external pin interrupt block: register offsets, reset values, field codes.
// Assumes inclusion by bare name from the package and the block's design file.
`ifndef EIP_CONSTS_SVH
`define EIP_CONSTS_SVH

// =====================================================================
// Register byte offsets
`define EIP_OFF_SENSE_LO      8'h00
`define EIP_OFF_SENSE_HI      8'h04
`define EIP_OFF_PIN_MASK      8'h08
`define EIP_OFF_PIN_FLAGS     8'h0c
`define EIP_OFF_GROUP_CTRL    8'h10
`define EIP_OFF_GROUP_FLAGS   8'h14
`define EIP_OFF_GROUP_MASK    8'h18
`define EIP_OFF_PIN_LEVELS    8'h1c

// =====================================================================
// Reset values
`define EIP_RST_SENSE_LO      8'h00
`define EIP_RST_SENSE_HI      8'h00
`define EIP_RST_PIN_MASK      8'h00
`define EIP_RST_PIN_FLAGS     8'h00
`define EIP_RST_GROUP_CTRL    8'h00
`define EIP_RST_GROUP_FLAGS   8'h00
`define EIP_RST_GROUP_MASK    8'h00

// =====================================================================
// Field positions and codes
`define EIP_GROUP_ENABLE_BIT  0
`define EIP_GROUP_FLAG_BIT    0
`define EIP_SENSE_LOW_LEVEL   2'h0
`define EIP_SENSE_ANY_EDGE    2'h1
`define EIP_SENSE_FALLING     2'h2
`define EIP_SENSE_RISING      2'h3
`define EIP_RESP_OKAY         2'h0
`define EIP_RESP_SLVERR       2'h2

`endif

// ---- design/eip_pkg.sv ----
// Types shared by the external pin interrupt block.
// Assumes eip_consts.svh is on the include path.
`include "eip_consts.svh"

package eip_pkg;

  // =====================================================================
  // Software visible control state
  typedef struct packed {
    logic [7:0] sense_select_low_pins;
    logic [7:0] sense_select_high_pins;
    logic [7:0] pin_interrupt_mask;
    logic [7:0] change_group_control;
    logic [7:0] change_group_mask;
  } eip_ctrl_type;

  // =====================================================================
  // Pin side signals of one port
  typedef struct packed {
    logic [7:0] level;
    logic [7:0] out_value;
    logic [7:0] out_enable;
  } eip_pins_type;

  typedef enum logic [1:0] {
    EIP_LOW_LEVEL = 2'b00,
    EIP_ANY_EDGE  = 2'b01,
    EIP_FALLING   = 2'b10,
    EIP_RISING    = 2'b11
  } eip_sense_type;

endpackage : eip_pkg

// ---- design/eip_external_pin_interrupts.sv ----
// External pin interrupt block: eight sense-selectable pins and one pin-change group.
// Assumes an AXI4-Lite master on aclk, a processor that acknowledges serviced vectors,
// and pads whose levels arrive asynchronously.
`timescale 1ns/100ps
`default_nettype none
`include "eip_consts.svh"

module eip_external_pin_interrupts #(
  parameter int PINS = 8
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire eip_pkg::eip_pins_type ext_irq_pins,
  input  wire eip_pkg::eip_pins_type change_group_pins,
  input  wire logic                io_clock_running,
  input  wire logic                sleep_active,
  input  wire logic                global_irq_enable,
  input  wire logic [PINS-1:0]     pin_irq_serviced,
  input  wire logic                change_group_serviced,
  output logic [PINS-1:0]          pin_irq_request,
  output logic                     change_group_request
);
  import eip_pkg::*;

  // =====================================================================
  // Register state
  eip_ctrl_type    ctrl;
  eip_ctrl_type    next_ctrl;
  logic [PINS-1:0] pin_interrupt_flags;
  logic [PINS-1:0] next_pin_interrupt_flags;
  logic            change_group_flag;
  logic            next_change_group_flag;

  // =====================================================================
  // Pad synchronisers: three stages, a change is taken once stages two and three agree.
  logic [PINS-1:0] irq_s1;
  logic [PINS-1:0] irq_s2;
  logic [PINS-1:0] irq_s3;
  logic [PINS-1:0] irq_level;
  logic [PINS-1:0] grp_s1;
  logic [PINS-1:0] grp_s2;
  logic [PINS-1:0] grp_s3;
  logic [PINS-1:0] grp_level;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // Stages start like their filtered levels, high for the pins and low for the group, so no false edge follows reset.
      irq_s1 <= {PINS{1'b1}};
      irq_s2 <= {PINS{1'b1}};
      irq_s3 <= {PINS{1'b1}};
      grp_s1 <= '0;
      grp_s2 <= '0;
      grp_s3 <= '0;
    end else begin
      irq_s1 <= ext_irq_pins.level;
      irq_s2 <= irq_s1;
      irq_s3 <= irq_s2;
      grp_s1 <= change_group_pins.level;
      grp_s2 <= grp_s1;
      grp_s3 <= grp_s2;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_level <= {PINS{1'b1}};
      grp_level <= '0;
    end else begin
      irq_level <= (irq_s2 & ~(irq_s2 ^ irq_s3)) | (irq_level & (irq_s2 ^ irq_s3));
      grp_level <= (grp_s2 & ~(grp_s2 ^ grp_s3)) | (grp_level & (grp_s2 ^ grp_s3));
    end
  end

  // =====================================================================
  // Effective pin values seen by the detectors.
  // Outside sleep a pin driven as an output is seen at its driven value, which lets software raise
  // an interrupt by writing the pin without waiting for the pad round trip.
  wire [PINS-1:0] buffer_off;
  wire [PINS-1:0] irq_value;
  wire [PINS-1:0] grp_value;

  assign buffer_off = {{(PINS-4){1'b0}}, {4{sleep_active}} & ~ctrl.pin_interrupt_mask[3:0]};
  assign irq_value  = ((ext_irq_pins.out_enable & ext_irq_pins.out_value)
                     | (~ext_irq_pins.out_enable & irq_level)) & ~buffer_off;
  assign grp_value  = (change_group_pins.out_enable & change_group_pins.out_value)
                     | (~change_group_pins.out_enable & grp_level);

  // =====================================================================
  // Previous samples for edge detection.
  // The always-on clock stands in for the asynchronous path; the upper pins only take a
  // new sample while the I/O clock runs, so their edges freeze when it halts.
  logic [PINS-1:0] irq_prev;
  logic [PINS-1:0] grp_prev;
  wire  [PINS-1:0] sample_en;

  assign sample_en = {{(PINS-4){io_clock_running}}, 4'hf};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_prev <= {PINS{1'b1}};
      grp_prev <= '0;
    end else begin
      irq_prev <= (irq_value & sample_en) | (irq_prev & ~sample_en);
      grp_prev <= grp_value;
    end
  end

  // =====================================================================
  // Per pin sense decode.
  // Reprogramming the sense field while enabled can look like an edge; this is left
  // visible so software follows the mask, reprogram, clear, re-enable order.
  wire [PINS-1:0] edge_event;
  wire [PINS-1:0] level_sense;
  wire [PINS-1:0] low_active;

  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi++) begin : g_pin
      wire [15:0]     sense_all;
      eip_sense_type  sense;
      wire            rise;
      wire            fall;
      assign sense_all = {ctrl.sense_select_high_pins, ctrl.sense_select_low_pins};
      assign sense     = eip_sense_type'(sense_all[2*gi+1 -: 2]);
      assign rise      = sample_en[gi] & irq_value[gi] & ~irq_prev[gi];
      assign fall      = sample_en[gi] & ~irq_value[gi] & irq_prev[gi];
      assign level_sense[gi] = (sense == EIP_LOW_LEVEL);
      assign low_active[gi]  = level_sense[gi] & ~irq_value[gi];
      assign edge_event[gi]  = ((sense == EIP_ANY_EDGE) & (rise | fall))
                             | ((sense == EIP_FALLING) & fall)
                             | ((sense == EIP_RISING) & rise);
    end
  endgenerate

  wire [PINS-1:0] grp_change;
  wire            grp_event;

  assign grp_change = (grp_value ^ grp_prev) & ctrl.change_group_mask;
  assign grp_event  = |grp_change;

  // =====================================================================
  // AXI4-Lite write path: address and data are held independently, then applied together.
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  wire         aw_fire;
  wire         w_fire;
  wire         wr_go;
  wire [7:0]   wr_addr;
  wire [31:0]  wr_data;
  wire         wr_byte;
  wire         wr_mapped;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign aw_fire   = s_axi_awvalid && s_axi_awready;
  assign w_fire    = s_axi_wvalid && s_axi_wready;
  assign wr_go     = (aw_held || aw_fire) && (w_held || w_fire) && !s_axi_bvalid;
  assign wr_addr   = aw_held ? aw_addr : s_axi_awaddr;
  assign wr_data   = w_held ? w_data : s_axi_wdata;
  assign wr_byte   = wr_go && (w_held ? w_strb[0] : s_axi_wstrb[0]);
  assign wr_mapped = (wr_addr[7:5] == 3'h0) && (wr_addr[1:0] == 2'h0);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      aw_held <= !wr_go && (aw_held || aw_fire);
      w_held  <= !wr_go && (w_held || w_fire);
      if (aw_fire) begin
        aw_addr <= s_axi_awaddr;
      end
      if (w_fire) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `EIP_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_mapped ? `EIP_RESP_OKAY : `EIP_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // =====================================================================
  // Register updates. A set arriving in the cycle of a clear wins, so no event is lost.
  wire wr_sense_lo = wr_byte && (wr_addr == `EIP_OFF_SENSE_LO);
  wire wr_sense_hi = wr_byte && (wr_addr == `EIP_OFF_SENSE_HI);
  wire wr_mask     = wr_byte && (wr_addr == `EIP_OFF_PIN_MASK);
  wire wr_flags    = wr_byte && (wr_addr == `EIP_OFF_PIN_FLAGS);
  wire wr_gctrl    = wr_byte && (wr_addr == `EIP_OFF_GROUP_CTRL);
  wire wr_gflags   = wr_byte && (wr_addr == `EIP_OFF_GROUP_FLAGS);
  wire wr_gmask    = wr_byte && (wr_addr == `EIP_OFF_GROUP_MASK);

  wire [PINS-1:0] flag_clear;
  wire            gflag_clear;

  assign flag_clear  = (wr_flags ? wr_data[PINS-1:0] : '0) | pin_irq_serviced;
  assign gflag_clear = (wr_gflags & wr_data[`EIP_GROUP_FLAG_BIT]) | change_group_serviced;

  always_comb begin
    next_ctrl = ctrl;
    if (wr_sense_lo) begin
      next_ctrl.sense_select_low_pins = wr_data[7:0];
    end
    if (wr_sense_hi) begin
      next_ctrl.sense_select_high_pins = wr_data[7:0];
    end
    if (wr_mask) begin
      next_ctrl.pin_interrupt_mask = wr_data[7:0];
    end
    if (wr_gctrl) begin
      next_ctrl.change_group_control = {7'h00, wr_data[`EIP_GROUP_ENABLE_BIT]};
    end
    if (wr_gmask) begin
      next_ctrl.change_group_mask = wr_data[7:0];
    end
  end

  assign next_pin_interrupt_flags = ((pin_interrupt_flags & ~flag_clear) | edge_event) & ~level_sense;
  assign next_change_group_flag   = (change_group_flag & ~gflag_clear) | grp_event;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl.sense_select_low_pins  <= `EIP_RST_SENSE_LO;
      ctrl.sense_select_high_pins <= `EIP_RST_SENSE_HI;
      ctrl.pin_interrupt_mask     <= `EIP_RST_PIN_MASK;
      ctrl.change_group_control   <= `EIP_RST_GROUP_CTRL;
      ctrl.change_group_mask      <= `EIP_RST_GROUP_MASK;
      pin_interrupt_flags         <= `EIP_RST_PIN_FLAGS;
      change_group_flag           <= 1'b0;
    end else begin
      ctrl                <= next_ctrl;
      pin_interrupt_flags <= next_pin_interrupt_flags;
      change_group_flag   <= next_change_group_flag;
    end
  end

  // =====================================================================
  // Requests to the processor.
  // A level request follows the pin directly, so a pulse shorter than the instruction
  // in flight may be missed; that is the source's duty to avoid.
  assign pin_irq_request = ctrl.pin_interrupt_mask & {PINS{global_irq_enable}}
                         & (low_active | pin_interrupt_flags);
  assign change_group_request = change_group_flag & global_irq_enable
                              & ctrl.change_group_control[`EIP_GROUP_ENABLE_BIT];

  // =====================================================================
  // AXI4-Lite read path.
  logic [7:0] rd_byte;
  wire        ar_fire;

  assign s_axi_arready = !s_axi_rvalid;
  assign ar_fire       = s_axi_arvalid && s_axi_arready;

  always_comb begin
    unique case (s_axi_araddr)
      `EIP_OFF_SENSE_LO:    rd_byte = ctrl.sense_select_low_pins;
      `EIP_OFF_SENSE_HI:    rd_byte = ctrl.sense_select_high_pins;
      `EIP_OFF_PIN_MASK:    rd_byte = ctrl.pin_interrupt_mask;
      `EIP_OFF_PIN_FLAGS:   rd_byte = pin_interrupt_flags;
      `EIP_OFF_GROUP_CTRL:  rd_byte = ctrl.change_group_control;
      `EIP_OFF_GROUP_FLAGS: rd_byte = {7'h00, change_group_flag};
      `EIP_OFF_GROUP_MASK:  rd_byte = ctrl.change_group_mask;
      `EIP_OFF_PIN_LEVELS:  rd_byte = irq_value;
      default:              rd_byte = 8'h00;
    endcase
  end

  wire rd_mapped = (s_axi_araddr[7:5] == 3'h0) && (s_axi_araddr[1:0] == 2'h0);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `EIP_RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, rd_byte};
      s_axi_rresp  <= rd_mapped ? `EIP_RESP_OKAY : `EIP_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : eip_external_pin_interrupts
`default_nettype wire

// ---- testbench/eip_props.sv ----
// Checker for the pin interrupt block, bound to its top module.
// Assumes pads may move on any edge; a quiet counter gates pad-dependent checks.
`timescale 1ns/100ps
`default_nettype none
module eip_props #(
  parameter int PINS = 8
) (
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire logic                  s_axi_awvalid,
  input wire logic                  s_axi_awready,
  input wire logic                  s_axi_wvalid,
  input wire logic                  s_axi_wready,
  input wire logic [1:0]            s_axi_bresp,
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_bready,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic [31:0]           s_axi_rdata,
  input wire logic                  s_axi_rvalid,
  input wire logic                  s_axi_rready,
  input wire eip_pkg::eip_pins_type ext_irq_pins,
  input wire eip_pkg::eip_pins_type change_group_pins,
  input wire logic                  io_clock_running,
  input wire logic                  sleep_active,
  input wire logic                  global_irq_enable,
  input wire logic [PINS-1:0]       pin_irq_serviced,
  input wire logic                  change_group_serviced,
  input wire logic [PINS-1:0]       pin_irq_request,
  input wire logic                  change_group_request
);
  import eip_pkg::*;
  // ==========================================================================
  // Pad activity; the synchronisers need a few edges, so checks wait for calm.
  wire logic [49:0] pads = {ext_irq_pins, change_group_pins, io_clock_running, sleep_active};
  wire logic        nowr = !s_axi_awvalid && !s_axi_wvalid;
  wire logic        calm;
  logic [49:0]      prev;
  logic [2:0]       quiet;
  // Driven pins reach the detectors without a synchroniser, so the current cycle must be quiet too.
  assign calm = (quiet == 3'h7) && (pads == prev);
  always_ff @(posedge aclk) begin
    prev <= pads;
    if (!aresetn || pads != prev) begin
      quiet <= 3'h0;
    end else if (!calm) begin
      quiet <= quiet + 3'h1;
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================================
  // Requests and flags.
  property p_pin_global;
    pin_irq_request != '0 |-> global_irq_enable;
  endproperty
  a_pin_global: assert property (p_pin_global) else $error("pin request without global enable");
  property p_grp_global;
    change_group_request |-> global_irq_enable;
  endproperty
  a_grp_global: assert property (p_grp_global) else $error("group request without global enable");
  property p_pin_hold;
    (pin_irq_request != '0 && calm && nowr && pin_irq_serviced == '0) ##1 (global_irq_enable && pads == prev)
      |-> pin_irq_request == $past(pin_irq_request);
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("pin request moved while quiet");
  property p_grp_hold;
    (change_group_request && calm && nowr && !change_group_serviced) ##1 global_irq_enable
      |-> change_group_request;
  endproperty
  a_grp_hold: assert property (p_grp_hold) else $error("group request dropped unserviced");
  property p_grp_clear;
    change_group_serviced && calm |=> !change_group_request;
  endproperty
  a_grp_clear: assert property (p_grp_clear) else $error("group request survived service");
  // ==========================================================================
  // Register bus answers.
  property p_b_after;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid;
  endproperty
  a_b_after: assert property (p_b_after) else $error("no write response after address and data");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response not held");
  property p_r_after;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_after: assert property (p_r_after) else $error("no read data after address");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data not held");
endmodule : eip_props
bind eip_external_pin_interrupts eip_props #(.PINS(PINS)) eip_props_inst (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .ext_irq_pins(ext_irq_pins), .change_group_pins(change_group_pins), .io_clock_running(io_clock_running),
  .sleep_active(sleep_active), .global_irq_enable(global_irq_enable), .pin_irq_serviced(pin_irq_serviced),
  .change_group_serviced(change_group_serviced), .pin_irq_request(pin_irq_request),
  .change_group_request(change_group_request));
`default_nettype wire

// ---- testbench/eip_pin_source.sv ----
// Pads in front of the block: outside sources, and the block's own pin drivers.
// Assumes the bench moves levels just after a clock edge.
`timescale 1ns/100ps
`default_nettype none
module eip_pin_source (
  input  wire logic [7:0]            ext_level,
  input  wire logic [7:0]            drive_value,
  input  wire logic [7:0]            drive_enable,
  input  wire logic [7:0]            group_level,
  output wire eip_pkg::eip_pins_type ext_irq_pins,
  output wire eip_pkg::eip_pins_type change_group_pins
);
  import eip_pkg::*;
  // The wire shows the block's own value wherever its driver is enabled.
  // Sources hold each level until told otherwise, well past any start-up.
  assign ext_irq_pins = '{level: (drive_enable & drive_value) | (~drive_enable & ext_level),
                          out_value: drive_value, out_enable: drive_enable};
  assign change_group_pins = '{level: group_level, out_value: 8'h00, out_enable: 8'h00};
endmodule : eip_pin_source
`default_nettype wire

// ---- testbench/external_pin_interrupts_tb_top.sv ----
// Self-checking bench: register tasks, pad stimulus, verdict.
// Assumes design, package, checker and pad model are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "eip_consts.svh"
module external_pin_interrupts_tb_top;
  import eip_pkg::*;
  logic         aclk = 1'b0;
  logic         aresetn = 1'b0;
  logic [7:0]   awaddr = 8'h00, araddr = 8'h00, svc = 8'h00, req;
  logic [31:0]  wdata = 32'h0, rdata, d;
  logic         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic         awready, wready, bvalid, arready, rvalid, greq;
  logic [1:0]   bresp, rresp, r;
  logic         io_run = 1'b1, sleep = 1'b0, glob = 1'b0, gsvc = 1'b0;
  logic [7:0]   ext_lvl = 8'hff, drv_val = 8'h00, drv_en = 8'h00, grp_lvl = 8'hff;
  eip_pins_type ext_pins, grp_pins;
  int           error_cnt = 0, check_count = 0, cyc = 0;
  always #10 aclk = ~aclk;
  eip_pin_source eip_pin_source_inst (.ext_level(ext_lvl), .drive_value(drv_val), .drive_enable(drv_en),
    .group_level(grp_lvl), .ext_irq_pins(ext_pins), .change_group_pins(grp_pins));
  eip_external_pin_interrupts eip_external_pin_interrupts_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .ext_irq_pins(ext_pins), .change_group_pins(grp_pins), .io_clock_running(io_run),
    .sleep_active(sleep), .global_irq_enable(glob), .pin_irq_serviced(svc), .change_group_serviced(gsvc),
    .pin_irq_request(req), .change_group_request(greq));
  // ==========================================================================
  // Shared tasks.
  task automatic summarize();
    if (error_cnt == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, s, e);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask : wt
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] o);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    o = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] o);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    v = rdata;
    o = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic w(input logic [7:0] a, input logic [31:0] v);
    logic [1:0] o;
    wr(a, v, o);
    chk(32'(o), 32'(`EIP_RESP_OKAY));
  endtask : w
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    logic [1:0]  o;
    rd(a, v, o);
    chk(v, e);
    chk(32'(o), 32'(`EIP_RESP_OKAY));
  endtask : rc
  // A hang is cut short well past the expected run of about five hundred cycles.
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      summarize();
    end
  end
  // ==========================================================================
  // Scenarios.
  initial begin
    wt(4);
    aresetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rc(8'(4 * i), (i == 7) ? 32'hff : 32'h0);
      if (i != 3 && i != 5 && i < 7) begin
        w(8'(4 * i), 32'hff5b);
        rc(8'(4 * i), (i == 4) ? 32'h1 : 32'h5b);
        w(8'(4 * i), 32'h0);
      end
    end
    w(`EIP_OFF_PIN_FLAGS, 32'hff);
    w(`EIP_OFF_GROUP_FLAGS, 32'hff);
    wr(8'h20, 32'hff, r);
    chk(32'(r), 32'(`EIP_RESP_SLVERR));
    rd(8'h20, d, r);
    chk(d, 32'h0);
    chk(32'(r), 32'(`EIP_RESP_SLVERR));
    for (int p = 0; p < 8; p += 4) begin
      for (int c = 0; c < 4; c++) begin
        w((p == 0) ? `EIP_OFF_SENSE_LO : `EIP_OFF_SENSE_HI, 32'(c));
        w(`EIP_OFF_PIN_FLAGS, 32'hff);
        ext_lvl[p] <= 1'b0;
        wt(8);
        rc(`EIP_OFF_PIN_FLAGS, (c == 1 || c == 2) ? 32'h1 << p : 32'h0);
        ext_lvl[p] <= 1'b1;
        wt(8);
        rc(`EIP_OFF_PIN_FLAGS, (c != 0) ? 32'h1 << p : 32'h0);
      end
    end
    w(`EIP_OFF_PIN_FLAGS, 32'h0);
    rc(`EIP_OFF_PIN_FLAGS, 32'h10);
    w(`EIP_OFF_PIN_FLAGS, 32'h10);
    rc(`EIP_OFF_PIN_FLAGS, 32'h0);
    w(`EIP_OFF_SENSE_LO, 32'h0);
    w(`EIP_OFF_PIN_MASK, 32'h1);
    glob <= 1'b1;
    ext_lvl[0] <= 1'b0;
    wt(8);
    chk(32'(req), 32'h1);
    wt(20);
    chk(32'(req), 32'h1);
    rc(`EIP_OFF_PIN_FLAGS, 32'h0);
    glob <= 1'b0;
    wt(1);
    chk(32'(req), 32'h0);
    ext_lvl[0] <= 1'b1;
    glob <= 1'b1;
    wt(8);
    chk(32'(req), 32'h0);
    // Safe reconfiguration order, so the sense change cannot leave a stray request.
    w(`EIP_OFF_PIN_MASK, 32'h0);
    w(`EIP_OFF_SENSE_LO, 32'h33);
    w(`EIP_OFF_PIN_FLAGS, 32'hff);
    w(`EIP_OFF_PIN_MASK, 32'h1);
    ext_lvl[0] <= 1'b0;
    wt(8);
    ext_lvl[0] <= 1'b1;
    wt(8);
    chk(32'(req), 32'h1);
    svc <= 8'h01;
    wt(1);
    svc <= 8'h00;
    wt(1);
    chk(32'(req), 32'h0);
    drv_en <= 8'h04;
    wt(8);
    drv_val <= 8'h04;
    wt(8);
    rc(`EIP_OFF_PIN_FLAGS, 32'h04);
    drv_en <= 8'h00;
    w(`EIP_OFF_SENSE_HI, 32'h0c);
    ext_lvl[5] <= 1'b0;
    wt(8);
    w(`EIP_OFF_PIN_FLAGS, 32'hff);
    io_run <= 1'b0;
    ext_lvl[5] <= 1'b1;
    wt(8);
    rc(`EIP_OFF_PIN_FLAGS, 32'h0);
    io_run <= 1'b1;
    wt(8);
    rc(`EIP_OFF_PIN_FLAGS, 32'h20);
    w(`EIP_OFF_PIN_MASK, 32'h0);
    w(`EIP_OFF_SENSE_LO, 32'h08);
    w(`EIP_OFF_PIN_FLAGS, 32'hff);
    sleep <= 1'b1;
    wt(8);
    rc(`EIP_OFF_PIN_FLAGS, 32'h02);
    sleep <= 1'b0;
    w(`EIP_OFF_GROUP_MASK, 32'h04);
    w(`EIP_OFF_GROUP_CTRL, 32'h1);
    grp_lvl[3] <= 1'b0;
    wt(8);
    rc(`EIP_OFF_GROUP_FLAGS, 32'h0);
    grp_lvl[2] <= 1'b0;
    wt(8);
    rc(`EIP_OFF_GROUP_FLAGS, 32'h1);
    chk(32'(greq), 32'h1);
    w(`EIP_OFF_GROUP_CTRL, 32'h0);
    chk(32'(greq), 32'h0);
    w(`EIP_OFF_GROUP_CTRL, 32'h1);
    wt(8);
    gsvc <= 1'b1;
    wt(1);
    gsvc <= 1'b0;
    wt(1);
    chk(32'(greq), 32'h0);
    grp_lvl[2] <= 1'b1;
    wt(8);
    w(`EIP_OFF_GROUP_FLAGS, 32'h1);
    rc(`EIP_OFF_GROUP_FLAGS, 32'h0);
    summarize();
  end
endmodule : external_pin_interrupts_tb_top
`default_nettype wire
